// file: design/jtl_pkg.sv
package jtl_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] JTL_OFS_TEST_CTRL = 12'h032C;
  localparam logic [11:0] JTL_OFS_EXP_LO    = 12'h032D;
  localparam logic [11:0] JTL_OFS_EXP_HI    = 12'h032E;
  localparam logic [11:0] JTL_OFS_RESULT    = 12'h032F;
  localparam logic [11:0] JTL_OFS_SETUP     = 12'h0333;
  localparam logic [11:0] JTL_OFS_POLARITY  = 12'h0334;
  localparam logic [11:0] JTL_OFS_DEV_ID    = 12'h0400;
  localparam logic [11:0] JTL_OFS_BANK      = 12'h0401;
  localparam logic [11:0] JTL_OFS_LANE      = 12'h0402;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int          JTL_BIT_ENABLE   = 0;
  localparam int          JTL_BIT_CLEAR    = 1;
  localparam int          JTL_CONV_LSB     = 2;
  localparam int          JTL_IDX_LSB      = 4;
  localparam logic [7:0]  JTL_RST_BYTE     = 8'h00;
  localparam logic [1:0]  JTL_CONV_FIRST   = 2'h0;
  localparam logic [1:0]  JTL_CONV_SECOND  = 2'h2;
  localparam int          JTL_SAMPLE_W     = 16;
  localparam int          JTL_SAMPLES      = 4;

  // Register write/read strobe bundle from the serial control port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } jtl_req_t;

  // Link parameters captured from lane 0
  typedef struct packed {
    logic [7:0] dev_id;
    logic [3:0] adj_res;
    logic [3:0] bank_id;
    logic       adj_dir;
    logic       ph_adj;
    logic [4:0] lane_id;
  } jtl_lparm_t;

endpackage : jtl_pkg

// file: design/jtl_sample_check.sv
`timescale 1ns/10ps
module jtl_sample_check #(
  parameter int SAMPLE_W = jtl_pkg::JTL_SAMPLE_W,
  parameter int SAMPLES  = jtl_pkg::JTL_SAMPLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire logic                          enable,
  input  wire logic                          clear,
  input  wire logic [1:0]                    conv_sel,
  input  wire logic [1:0]                    idx_sel,
  input  wire logic [SAMPLE_W-1:0]           expected,
  input  wire logic                          smp_valid,
  input  wire logic [2*SAMPLES*SAMPLE_W-1:0] smp_data,
  output logic                               failed
);
  import jtl_pkg::*;

  // ----------------------------------------
  // Sample selection
  // ----------------------------------------
  logic [SAMPLES*SAMPLE_W-1:0] conv_bus;
  logic [SAMPLE_W-1:0]         picked;
  logic                        mismatch;
  logic                        en_q;
  logic                        en_rise;
  logic                        failed_q;

  // Odd converter codes are undefined; they fall back to the first one
  assign conv_bus = (conv_sel == JTL_CONV_SECOND) ?                       // RULE_01
                    smp_data[2*SAMPLES*SAMPLE_W-1:SAMPLES*SAMPLE_W] :
                    smp_data[SAMPLES*SAMPLE_W-1:0];
  assign picked   = conv_bus[idx_sel*SAMPLE_W +: SAMPLE_W];               // RULE_17
  assign mismatch = smp_valid && (picked != expected);                    // RULE_06
  assign en_rise  = enable && !en_q;

  // ----------------------------------------
  // Sticky fail flag
  // ----------------------------------------
  // A mismatch arriving with a clear still wins, so no event is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      en_q     <= 1'b0;
      failed_q <= 1'b0;
    end else begin
      en_q <= enable;
      if (enable && mismatch)
        failed_q <= 1'b1;                                                 // RULE_07
      else if (clear || en_rise)
        failed_q <= 1'b0;                                                 // RULE_02
    end
  end

  assign failed = failed_q;                                               // RULE_18

endmodule : jtl_sample_check

// file: design/jtl_regs.sv
`timescale 1ns/10ps
// Contract
// RULE_01 - converter select 0 first, 2 second
// RULE_02 - writing clear resets stored test result
// RULE_03 - enable bit 0 starts/stops test
// RULE_04 - low expected byte register, reset zero
// RULE_05 - high expected byte register
// RULE_06 - compare selected sample to reference
// RULE_07 - fail bit 0, upper bits zero
// RULE_08 - software writes 0x01 to setup
// RULE_09 - polarity bit inverts lane data
// RULE_10 - capture lane 0 link parameters
// RULE_11 - report received device identifier
// RULE_12 - adjust resolution in bank bits 7:4
// RULE_13 - bank identifier in low nibble
// RULE_14 - adjust direction at lane bit 6
// RULE_15 - phase adjust request at bit 5
// RULE_16 - lane identifier bits 4:0, bit7 zero
// RULE_17 - sample index selects compared sample
// RULE_18 - fail holds until clear or re-enable
module jtl_regs #(
  parameter int LANES    = 8,
  parameter int LANE_W   = 32,
  parameter int SAMPLE_W = jtl_pkg::JTL_SAMPLE_W,
  parameter int SAMPLES  = jtl_pkg::JTL_SAMPLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_b,
  input  wire jtl_pkg::jtl_req_t             req,
  output logic [7:0]                         rdata,
  output logic                               rvalid,
  input  wire logic [LANES*LANE_W-1:0]       lane_raw,
  output logic [LANES*LANE_W-1:0]            lane_fixed,
  input  wire logic                          lparm_valid,
  input  wire jtl_pkg::jtl_lparm_t           lparm_in,
  input  wire logic                          smp_valid,
  input  wire logic [2*SAMPLES*SAMPLE_W-1:0] smp_data,
  output logic                               setup_ok
);
  import jtl_pkg::*;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0]  ctrl_q;
  logic [7:0]  exp_lo_q;
  logic [7:0]  exp_hi_q;
  logic [7:0]  setup_q;
  logic [7:0]  pol_q;
  jtl_lparm_t  lparm_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [LANES*LANE_W-1:0] lane_q;
  wire  [LANES*LANE_W-1:0] lane_inv;
  logic        failed;
  logic        clear_pulse;

  // Address decode
  wire wr_ctrl  = req.wr && (req.addr == JTL_OFS_TEST_CTRL);
  wire wr_lo    = req.wr && (req.addr == JTL_OFS_EXP_LO);
  wire wr_hi    = req.wr && (req.addr == JTL_OFS_EXP_HI);
  wire wr_setup = req.wr && (req.addr == JTL_OFS_SETUP);
  wire wr_pol   = req.wr && (req.addr == JTL_OFS_POLARITY);

  // Clear acts once per write of a one; the stored bit only reads back
  assign clear_pulse = wr_ctrl && req.wdata[JTL_BIT_CLEAR];               // RULE_02

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q   <= JTL_RST_BYTE;                                           // RULE_03
      exp_lo_q <= JTL_RST_BYTE;                                           // RULE_04
      exp_hi_q <= JTL_RST_BYTE;
      setup_q  <= JTL_RST_BYTE;
      pol_q    <= JTL_RST_BYTE;
    end else begin
      if (wr_ctrl)  ctrl_q   <= {2'b00, req.wdata[5:0]};
      if (wr_lo)    exp_lo_q <= req.wdata;                                // RULE_04
      if (wr_hi)    exp_hi_q <= req.wdata;                                // RULE_05
      if (wr_setup) setup_q  <= req.wdata;
      if (wr_pol)   pol_q    <= req.wdata;
    end
  end

  // Setup value is only reported; the link cannot check software did it
  assign setup_ok = (setup_q == 8'h01);                                   // RULE_08

  // ----------------------------------------
  // Link parameter capture from lane 0
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      lparm_q <= '0;                                                      // RULE_10
    else if (lparm_valid)
      lparm_q <= lparm_in;                                                // RULE_10
  end

  // ----------------------------------------
  // Lane polarity inversion, one register stage for all lanes
  // ----------------------------------------
  // Per-lane XOR is combinational so a single process owns lane_q
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      wire [LANE_W-1:0] inv = {LANE_W{(g < 8) ? pol_q[g % 8] : 1'b0}};
      assign lane_inv[g*LANE_W +: LANE_W] = lane_raw[g*LANE_W +: LANE_W] ^ inv; // RULE_09
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      lane_q <= '0;
    else
      lane_q <= lane_inv;                                                 // RULE_09
  end
  assign lane_fixed = lane_q;

  // ----------------------------------------
  // Transport sample check
  // ----------------------------------------
  jtl_sample_check #(
    .SAMPLE_W (SAMPLE_W),
    .SAMPLES  (SAMPLES)
  ) u_check (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .enable    (ctrl_q[JTL_BIT_ENABLE]),                                  // RULE_03
    .clear     (clear_pulse),
    .conv_sel  (ctrl_q[JTL_CONV_LSB +: 2]),                               // RULE_01
    .idx_sel   (ctrl_q[JTL_IDX_LSB +: 2]),                                // RULE_17
    .expected  ({exp_hi_q, exp_lo_q}),                                    // RULE_05
    .smp_valid (smp_valid),
    .smp_data  (smp_data),
    .failed    (failed)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;                                                       // Unmapped reads zero
    unique case (req.addr)
      JTL_OFS_TEST_CTRL: rd_mux = ctrl_q;
      JTL_OFS_EXP_LO:    rd_mux = exp_lo_q;
      JTL_OFS_EXP_HI:    rd_mux = exp_hi_q;
      JTL_OFS_RESULT:    rd_mux = {7'h00, failed};                        // RULE_07
      JTL_OFS_SETUP:     rd_mux = setup_q;
      JTL_OFS_POLARITY:  rd_mux = pol_q;
      JTL_OFS_DEV_ID:    rd_mux = lparm_q.dev_id;                         // RULE_11
      JTL_OFS_BANK:      rd_mux = {lparm_q.adj_res, lparm_q.bank_id};     // RULE_12 RULE_13
      JTL_OFS_LANE:      rd_mux = {1'b0, lparm_q.adj_dir,                 // RULE_14
                                   lparm_q.ph_adj, lparm_q.lane_id};      // RULE_15 RULE_16
      default:           rd_mux = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) rdata_q <= rd_mux;
    end
  end

  assign rdata  = rdata_q;
  assign rvalid = rvalid_q;

endmodule : jtl_regs

// file: tb/jtl_regs_monitor.sv
`timescale 1ns/10ps
module jtl_regs_monitor #(
  parameter int LANES    = 8,
  parameter int LANE_W   = 32,
  parameter int SAMPLE_W = jtl_pkg::JTL_SAMPLE_W,
  parameter int SAMPLES  = jtl_pkg::JTL_SAMPLES
) (
  input wire logic                          clk_sys,
  input wire logic                          rst_b,
  input wire jtl_pkg::jtl_req_t             req,
  input wire logic [7:0]                    rdata,
  input wire logic                          rvalid,
  input wire logic [LANES*LANE_W-1:0]       lane_raw,
  input wire logic [LANES*LANE_W-1:0]       lane_fixed,
  input wire logic                          lparm_valid,
  input wire jtl_pkg::jtl_lparm_t           lparm_in,
  input wire logic                          smp_valid,
  input wire logic [2*SAMPLES*SAMPLE_W-1:0] smp_data,
  input wire logic                          setup_ok
);
  import jtl_pkg::*;
  // ----
  // Shadows of the polarity and setup registers and of captured link parameters, so reads, lane 0 inversion and the setup flag can be judged
  // ----
  logic [7:0] pol_q;
  logic [7:0] set_q;
  jtl_lparm_t lp_q;
  wire [7:0] lane_b = {1'b0, lp_q.adj_dir, lp_q.ph_adj, lp_q.lane_id};
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      pol_q <= '0;
      set_q <= '0;
      lp_q <= '0;
    end else begin
      if (req.wr && req.addr == JTL_OFS_POLARITY) pol_q <= req.wdata;
      if (req.wr && req.addr == JTL_OFS_SETUP) set_q <= req.wdata;
      if (lparm_valid) lp_q <= lparm_in;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  rd_answer_a: assert property (req.rd |=> rvalid) else $error("read not answered");
  rd_only_a: assert property (rvalid |-> $past(req.rd)) else $error("stray read answer");
  lane_inv_a: assert property ($past(rst_b) |-> lane_fixed[31:0] ==
    ($past(lane_raw[31:0]) ^ {32{$past(pol_q[0])}})) else $error("lane 0 inversion wrong");
  setup_flag_a: assert property (setup_ok == (set_q == 8'h01)) else $error("setup flag wrong");
  res_resv_a: assert property (req.rd && req.addr == JTL_OFS_RESULT |=> rdata[7:1] == 7'h00)
    else $error("result upper bits set");
  pol_read_a: assert property (req.rd && req.addr == JTL_OFS_POLARITY |=> rdata == $past(pol_q))
    else $error("polarity readback wrong");
  unmap_zero_a: assert property (req.rd && req.addr == 12'h0330 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  lane_read_a: assert property (req.rd && req.addr == JTL_OFS_LANE |=> rdata == $past(lane_b))
    else $error("lane register read wrong");
endmodule : jtl_regs_monitor
bind jtl_regs jtl_regs_monitor #(.LANES(LANES), .LANE_W(LANE_W), .SAMPLE_W(SAMPLE_W), .SAMPLES(SAMPLES)) u_mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid), .lane_raw(lane_raw),
  .lane_fixed(lane_fixed), .lparm_valid(lparm_valid), .lparm_in(lparm_in), .smp_valid(smp_valid),
  .smp_data(smp_data), .setup_ok(setup_ok));

// file: tb/jtl_tx_model.sv
`timescale 1ns/10ps
module jtl_tx_model (
  input wire logic            clk_sys,
  output logic [255:0]        lane_raw,
  output logic                lparm_valid,
  output jtl_pkg::jtl_lparm_t lparm_in,
  output logic                smp_valid,
  output logic [127:0]        smp_data
);
  import jtl_pkg::*;
  logic [127:0] pend[$];
  initial begin
    lparm_valid = 1'b0;
    lparm_in = '0;
  end
  // ----
  // Lanes churn every cycle; idle samples invert the previous data each cycle
  // ----
  always @(negedge clk_sys) begin
    for (int k = 0; k < 8; k++) lane_raw[k*32 +: 32] <= $urandom;
    smp_valid <= (pend.size() != 0);
    smp_data <= (pend.size() != 0) ? pend.pop_front() : ~smp_data;
  end
  task send_frame(input logic [127:0] d);
    pend.push_back(d);
  endtask : send_frame
  // Adjust fields always zero; held value inverted after release
  task send_params(input logic [7:0] dev, input logic [3:0] bank, input logic [4:0] lane);
    @(negedge clk_sys);
    lparm_valid = 1'b1;
    lparm_in = '{dev, 4'h0, bank, 1'b0, 1'b0, lane};
    @(negedge clk_sys);
    lparm_valid = 1'b0;
    lparm_in = ~lparm_in;
  endtask : send_params
endmodule : jtl_tx_model

// file: tb/tb_jtl_regs.sv
`timescale 1ns/10ps
module tb_jtl_regs;
  import jtl_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, setup_ok, rvalid, lparm_valid, smp_valid;
  jtl_req_t req = '0;
  jtl_lparm_t lparm_in;
  logic [7:0] rdata, mk, e8[$];
  logic [255:0] lane_raw, lane_fixed, m;
  logic [127:0] smp_data;
  logic [15:0] ref_v;
  int err_total = 0, compares = 0, pos;
  always #10 clk_sys = ~clk_sys;
  jtl_regs u_jtl_regs (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
    .lane_raw(lane_raw), .lane_fixed(lane_fixed), .lparm_valid(lparm_valid), .lparm_in(lparm_in),
    .smp_valid(smp_valid), .smp_data(smp_data), .setup_ok(setup_ok));
  jtl_tx_model u_jtl_tx_model (.clk_sys(clk_sys), .lane_raw(lane_raw), .lparm_valid(lparm_valid),
    .lparm_in(lparm_in), .smp_valid(smp_valid), .smp_data(smp_data));
  // ----
  // Checking and bus tasks
  // ----
  task chk(input logic [255:0] got, input logic [255:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // One cycle per access; a read queues its expected byte
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{w, !w, a, d};
    if (!w) e8.push_back(d);
  endtask : acc
  task idle(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      req = '0;
    end
  endtask : idle
  // Selected slot gets s, every other slot gets o
  task frame(input logic [15:0] s, input logic [15:0] o);
    logic [127:0] d;
    d = {8{o}};
    d[pos*16 +: 16] = s;
    idle(1);
    u_jtl_tx_model.send_frame(d);
    idle(3);
  endtask : frame
  // Read answers are matched against the oldest note
  always @(negedge clk_sys) begin
    if (rvalid === 1'b1) begin
      if (e8.size() == 0) chk(1, 0);
      else chk(rdata, e8.pop_front());
    end
  end
  initial begin
    #1900000;
    err_total++;
    conclude();
  end
  initial begin
    void'($urandom(15302));
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    for (int a = 'h32C; a <= 'h334; a++) acc(0, a[11:0], 8'h00);
    for (int a = 'h400; a <= 'h402; a++) acc(0, a[11:0], 8'h00);
    idle(3);
    $display("test reset values done");
    acc(1, JTL_OFS_SETUP, 8'h01);
    acc(0, JTL_OFS_SETUP, 8'h01);
    idle(2);
    chk(setup_ok, 1);
    ref_v = 16'($urandom);
    acc(1, JTL_OFS_EXP_LO, ref_v[7:0]);
    acc(1, JTL_OFS_EXP_HI, ref_v[15:8]);
    acc(0, JTL_OFS_EXP_LO, ref_v[7:0]);
    acc(0, JTL_OFS_EXP_HI, ref_v[15:8]);
    idle(2);
    $display("test setup and reference done");
    for (int c = 0; c < 4; c++) for (int i = 0; i < 4; i++) begin
      pos = (c == 2 ? 4 : 0) + i;
      acc(1, JTL_OFS_TEST_CTRL, {2'b00, i[1:0], c[1:0], 2'b01});
      acc(0, JTL_OFS_TEST_CTRL, {2'b00, i[1:0], c[1:0], 2'b01});
      frame(ref_v, ~ref_v);
      acc(0, JTL_OFS_RESULT, 8'h00);
      frame(~ref_v, ref_v);
      acc(0, JTL_OFS_RESULT, 8'h01);
      acc(1, JTL_OFS_TEST_CTRL, {2'b00, i[1:0], c[1:0], 2'b01});
      acc(0, JTL_OFS_RESULT, 8'h01);
      acc(1, JTL_OFS_TEST_CTRL, {2'b00, i[1:0], c[1:0], 2'b11});
      acc(0, JTL_OFS_RESULT, 8'h00);
      acc(1, JTL_OFS_TEST_CTRL, 8'h00);
      frame(~ref_v, ref_v);
      acc(0, JTL_OFS_RESULT, 8'h00);
    end
    $display("test sample check done");
    mk = 8'($urandom);
    acc(1, JTL_OFS_POLARITY, mk);
    acc(0, JTL_OFS_POLARITY, mk);
    idle(2);
    for (int k = 0; k < 8; k++) m[k*32 +: 32] = {32{mk[k]}};
    repeat (4) begin
      @(negedge clk_sys);
      chk(lane_fixed, lane_raw ^ m);
    end
    $display("test lane inversion done");
    u_jtl_tx_model.send_params(mk, ref_v[3:0], ref_v[8:4]);
    acc(0, JTL_OFS_DEV_ID, mk);
    acc(0, JTL_OFS_BANK, {4'h0, ref_v[3:0]});
    acc(0, JTL_OFS_LANE, {3'b000, ref_v[8:4]});
    idle(4);
    chk(e8.size(), 0);
    $display("test link parameters done");
    conclude();
  end
endmodule : tb_jtl_regs
